//--- logic/ccg_regs.svh
`ifndef CCG_REGS_SVH
`define CCG_REGS_SVH

// ----------------------------------------------------------------------------
// Datapath widths
// ----------------------------------------------------------------------------
`define CCG_DATA_W 36
`define CCG_STATE_W 8

// ----------------------------------------------------------------------------
// Bit positions inside the accumulator result
// ----------------------------------------------------------------------------
`define CCG_ACC_MSB 35
`define CCG_ACC_LSB 0
`define CCG_UPPER_MSB 31
`define CCG_UPPER_LSB 16
`define CCG_SHORT_MSB 15
`define CCG_SHORT_LSB 0
`define CCG_EXT_CHK_LSB 31
`define CCG_NORM_HI 31
`define CCG_NORM_LO 30

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCG_STATE_RST 8'h00

`endif

//--- logic/ccg_pkg.sv
package ccg_pkg;

  // --------------------------------------------------------------------------
  // Instruction classes seen by the flag logic
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CCG_OP_NONE        = 3'h0,
    CCG_OP_ARITH       = 3'h1,
    CCG_OP_WORD_INCDEC = 3'h2,
    CCG_OP_LOGICAL     = 3'h3,
    CCG_OP_BITFIELD    = 3'h4,
    CCG_OP_CLEAR       = 3'h5,
    CCG_OP_ACC_TEST    = 3'h6,
    CCG_OP_SHORT_TEST  = 3'h7
  } ccg_op_class_t;

  // --------------------------------------------------------------------------
  // Destination kind
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    CCG_DEST_SHORT = 1'h0,
    CCG_DEST_ACC   = 1'h1
  } ccg_dest_t;

  // --------------------------------------------------------------------------
  // Registered state of the generator
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic lim;
    logic ext;
    logic unnorm;
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
    logic done;
  } ccg_state_t;

endpackage

//--- logic/ccg_width_flags.sv
`timescale 1ns/10ps
`include "ccg_regs.svh"

// Flags of one result slice: sign, zero, carry or borrow out, overflow
module ccg_width_flags #(
  parameter int unsigned MSB = 35,
  parameter int unsigned LSB = 0
) (
  input wire logic [`CCG_DATA_W-1:0] i_op_a,
  input wire logic [`CCG_DATA_W-1:0] i_op_b,
  input wire logic [`CCG_DATA_W-1:0] i_result,
  input wire logic i_sub,
  output logic o_neg,
  output logic o_zero,
  output logic o_carry,
  output logic o_ovf
);

  logic a;
  logic b;
  logic r;

  assign a = i_op_a[MSB];
  assign b = i_op_b[MSB];
  assign r = i_result[MSB];
  assign o_neg = r;
  assign o_zero = ~|i_result[MSB:LSB];
  // Carry out of the top bit is recovered from a, b and the sum bit
  assign o_carry = i_sub ? ((~a & b) | ((~a | b) & r)) : ((a & b) | ((a | b) & ~r));
  assign o_ovf = i_sub ? ((a ^ b) & (a ^ r)) : ((a ^ r) & (b ^ r));

endmodule

//--- logic/ccg_ext_check.sv
`timescale 1ns/10ps
`include "ccg_regs.svh"

// Extension-in-use and unnormalized detection on the full result
module ccg_ext_check (
  input wire logic [`CCG_DATA_W-1:0] i_result,
  output logic o_ext_in_use,
  output logic o_unnorm
);

  logic [`CCG_ACC_MSB-`CCG_EXT_CHK_LSB:0] top_bits;

  assign top_bits = i_result[`CCG_ACC_MSB:`CCG_EXT_CHK_LSB];
  // Any disagreement among the top five bits means the extension holds data
  assign o_ext_in_use = ~((&top_bits) | (~|top_bits));
  // Unnormalized when the two bits below the binary point agree
  assign o_unnorm = ~(i_result[`CCG_NORM_HI] ^ i_result[`CCG_NORM_LO]);

endmodule

//--- logic/ccg_top.sv
`timescale 1ns/10ps
`include "ccg_regs.svh"

// Behaviour
// - Extension and unnormalized flags ignore destination width and mode; limit follows the overflow width.
// - Arithmetic sets limit on overflow or on parallel-move limiting.
// - Extension flag set when accumulator bits 35 to 31 disagree.
// - Mode clear, full accumulator: negative from bit 35; saturation sets overflow, clears negative.
// - Mode clear, full accumulator: zero only when bits 35 to 0 are zero.
// - Mode clear, full accumulator: overflow at 36 bits, carry out of bit 35.
// - Mode set, full accumulator: ignore extension, negative bit 31, zero bits 31-0.
// - Mode set, full accumulator: overflow at 32 bits, carry out of bit 31.
// - Word inc/dec, mode clear: flags from bits 35-16, overflow at 20 bits.
// - Word inc/dec, mode set: flags from bits 31-16, overflow at 16 bits.
// - Short destination arithmetic: flags from bits 15-0, mode ignored.
// - Logical to short register: negative bit 15, zero 15-0, overflow clear.
// - Logical to accumulator: negative bit 31, zero 31-16, overflow clear.
// - Bit-field operations change only carry and limit.
// - Clear updates flags only for an accumulator target.
// - Accumulator test clears overflow and carry, limit only from move limiting.
// - Short value test: limit on limited read, sign bit 15, zero, clears V and C.
module ccg_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire ccg_pkg::ccg_op_class_t i_op_class,
  input wire ccg_pkg::ccg_dest_t i_dest,
  input wire logic i_ignore_extension_mode_bit,
  input wire logic [`CCG_DATA_W-1:0] i_op_a,
  input wire logic [`CCG_DATA_W-1:0] i_op_b,
  input wire logic [`CCG_DATA_W-1:0] i_result,
  input wire logic i_sub,
  input wire logic i_saturated,
  input wire logic i_move_limited,
  input wire logic i_read_limited,
  input wire logic i_logic_carry,
  input wire logic i_bitfield_carry,
  output logic o_flag_lim,
  output logic o_flag_ext,
  output logic o_flag_unnorm,
  output logic o_flag_neg,
  output logic o_flag_zero,
  output logic o_flag_ovf,
  output logic o_flag_carry,
  output logic o_update_done
);

  // --------------------------------------------------------------------------
  // Slice flag generators
  // --------------------------------------------------------------------------
  logic f36_neg;
  logic f36_zero;
  logic f36_carry;
  logic f36_ovf;
  logic f32_neg;
  logic f32_zero;
  logic f32_carry;
  logic f32_ovf;
  logic f20_neg;
  logic f20_zero;
  logic f20_carry;
  logic f20_ovf;
  logic f16u_neg;
  logic f16u_zero;
  logic f16u_carry;
  logic f16u_ovf;
  logic f16_neg;
  logic f16_zero;
  logic f16_carry;
  logic f16_ovf;
  logic ext_in_use;
  logic unnorm;
  logic mode_set;
  logic is_acc;

  assign mode_set = i_ignore_extension_mode_bit;
  assign is_acc = (i_dest == ccg_pkg::CCG_DEST_ACC);

  ccg_width_flags #(.MSB(`CCG_ACC_MSB), .LSB(`CCG_ACC_LSB)) u_full36 (
    .i_op_a(i_op_a),
    .i_op_b(i_op_b),
    .i_result(i_result),
    .i_sub(i_sub),
    .o_neg(f36_neg),
    .o_zero(f36_zero),
    .o_carry(f36_carry),
    .o_ovf(f36_ovf)
  );

  ccg_width_flags #(.MSB(`CCG_UPPER_MSB), .LSB(`CCG_ACC_LSB)) u_full32 (
    .i_op_a(i_op_a),
    .i_op_b(i_op_b),
    .i_result(i_result),
    .i_sub(i_sub),
    .o_neg(f32_neg),
    .o_zero(f32_zero),
    .o_carry(f32_carry),
    .o_ovf(f32_ovf)
  );

  ccg_width_flags #(.MSB(`CCG_ACC_MSB), .LSB(`CCG_UPPER_LSB)) u_upper20 (
    .i_op_a(i_op_a),
    .i_op_b(i_op_b),
    .i_result(i_result),
    .i_sub(i_sub),
    .o_neg(f20_neg),
    .o_zero(f20_zero),
    .o_carry(f20_carry),
    .o_ovf(f20_ovf)
  );

  ccg_width_flags #(.MSB(`CCG_UPPER_MSB), .LSB(`CCG_UPPER_LSB)) u_upper16 (
    .i_op_a(i_op_a),
    .i_op_b(i_op_b),
    .i_result(i_result),
    .i_sub(i_sub),
    .o_neg(f16u_neg),
    .o_zero(f16u_zero),
    .o_carry(f16u_carry),
    .o_ovf(f16u_ovf)
  );

  ccg_width_flags #(.MSB(`CCG_SHORT_MSB), .LSB(`CCG_SHORT_LSB)) u_short16 (
    .i_op_a(i_op_a),
    .i_op_b(i_op_b),
    .i_result(i_result),
    .i_sub(i_sub),
    .o_neg(f16_neg),
    .o_zero(f16_zero),
    .o_carry(f16_carry),
    .o_ovf(f16_ovf)
  );

  // Same detector for every class and mode
  ccg_ext_check u_ext (
    .i_result(i_result),
    .o_ext_in_use(ext_in_use),
    .o_unnorm(unnorm)
  );

  // --------------------------------------------------------------------------
  // Flag selection
  // --------------------------------------------------------------------------
  ccg_pkg::ccg_state_t state_q;
  ccg_pkg::ccg_state_t state_d;

  always_comb begin
    state_d = state_q;
    state_d.done = 1'b0;
    if (i_valid) begin
      case (i_op_class)
        ccg_pkg::CCG_OP_ARITH, ccg_pkg::CCG_OP_WORD_INCDEC: begin
          state_d.done = 1'b1;
          state_d.ext = ext_in_use;
          state_d.unnorm = unnorm;
          if (!is_acc) begin
            state_d.neg = f16_neg;
            state_d.zero = f16_zero;
            state_d.ovf = f16_ovf;
            state_d.carry = f16_carry;
          end else if (i_op_class == ccg_pkg::CCG_OP_ARITH) begin
            if (!mode_set) begin
              state_d.neg = f36_neg & ~i_saturated;
              state_d.zero = f36_zero;
              state_d.ovf = f36_ovf | i_saturated;
              state_d.carry = f36_carry;
            end else begin
              state_d.neg = f32_neg;
              state_d.zero = f32_zero;
              state_d.ovf = f32_ovf;
              state_d.carry = f32_carry;
            end
          end else begin
            if (!mode_set) begin
              state_d.neg = f20_neg & ~i_saturated;
              state_d.zero = f20_zero;
              state_d.ovf = f20_ovf | i_saturated;
              state_d.carry = f20_carry;
            end else begin
              state_d.neg = f16u_neg;
              state_d.zero = f16u_zero;
              state_d.ovf = f16u_ovf;
              state_d.carry = f16u_carry;
            end
          end
          state_d.lim = state_d.ovf | i_move_limited;
        end
        ccg_pkg::CCG_OP_LOGICAL: begin
          state_d.done = 1'b1;
          state_d.ext = ext_in_use;
          state_d.unnorm = unnorm;
          state_d.ovf = 1'b0;
          state_d.carry = i_logic_carry;
          state_d.lim = i_move_limited;
          if (is_acc) begin
            state_d.neg = f16u_neg;
            state_d.zero = f16u_zero;
          end else begin
            state_d.neg = f16_neg;
            state_d.zero = f16_zero;
          end
        end
        ccg_pkg::CCG_OP_BITFIELD: begin
          // Only carry and limit move
          state_d.done = 1'b1;
          state_d.carry = i_bitfield_carry;
          state_d.lim = i_move_limited;
        end
        ccg_pkg::CCG_OP_CLEAR: begin
          // Flags of a cleared accumulator; other targets keep all flags
          if (is_acc) begin
            state_d.done = 1'b1;
            state_d.ext = ext_in_use;
            state_d.unnorm = unnorm;
            state_d.neg = mode_set ? f32_neg : f36_neg;
            state_d.zero = mode_set ? f32_zero : f36_zero;
            state_d.ovf = 1'b0;
            state_d.carry = 1'b0;
            state_d.lim = i_move_limited;
          end
        end
        ccg_pkg::CCG_OP_ACC_TEST: begin
          state_d.done = 1'b1;
          state_d.ext = ext_in_use;
          state_d.unnorm = unnorm;
          state_d.neg = mode_set ? f32_neg : f36_neg;
          state_d.zero = mode_set ? f32_zero : f36_zero;
          state_d.ovf = 1'b0;
          state_d.carry = 1'b0;
          state_d.lim = i_move_limited;
        end
        ccg_pkg::CCG_OP_SHORT_TEST: begin
          state_d.done = 1'b1;
          state_d.neg = f16_neg;
          state_d.zero = f16_zero;
          state_d.ovf = 1'b0;
          state_d.carry = 1'b0;
          state_d.lim = i_read_limited;
        end
        default: begin
          state_d.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= ccg_pkg::ccg_state_t'(`CCG_STATE_RST);
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_flag_lim = state_q.lim;
  assign o_flag_ext = state_q.ext;
  assign o_flag_unnorm = state_q.unnorm;
  assign o_flag_neg = state_q.neg;
  assign o_flag_zero = state_q.zero;
  assign o_flag_ovf = state_q.ovf;
  assign o_flag_carry = state_q.carry;
  assign o_update_done = state_q.done;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  logic [32:0] ref_add32;
  logic arith_full;
  logic arith_acc;

  assign ref_add32 = {1'b0, i_op_a[31:0]} + {1'b0, i_op_b[31:0]};
  assign arith_acc = i_valid && is_acc && (i_op_class == ccg_pkg::CCG_OP_ARITH);
  assign arith_full = arith_acc && !mode_set;

  chk_ext_flag: assert property (
    (i_valid && i_op_class == ccg_pkg::CCG_OP_ACC_TEST) |=>
      (o_flag_ext == !((&$past(i_result[35:31])) || !(|$past(i_result[35:31])))))
    else $error("extension flag wrong after accumulator test");

  chk_sat_neg: assert property (
    (arith_full && i_saturated) |=> (o_flag_ovf && !o_flag_neg))
    else $error("saturation did not set overflow and clear negative");

  chk_zero_full: assert property (
    arith_full |=> (o_flag_zero == ($past(i_result) == 36'h0)))
    else $error("zero flag wrong for full accumulator");

  chk_mode_set_zero: assert property (
    (arith_acc && mode_set) |=>
      (o_flag_zero == ($past(i_result[31:0]) == 32'h0) && o_flag_neg == $past(i_result[31])))
    else $error("mode set zero or negative wrong");

  chk_carry_bit31: assert property (
    (arith_acc && mode_set && !i_sub && i_result[31:0] == ref_add32[31:0]) |=>
      (o_flag_carry == $past(ref_add32[32])))
    else $error("carry out of bit 31 wrong");

  chk_word_zero: assert property (
    (i_valid && is_acc && !mode_set && i_op_class == ccg_pkg::CCG_OP_WORD_INCDEC) |=>
      (o_flag_zero == ($past(i_result[35:16]) == 20'h0)))
    else $error("word inc/dec zero flag wrong");

  chk_short_arith: assert property (
    (i_valid && !is_acc && i_op_class == ccg_pkg::CCG_OP_ARITH) |=>
      (o_flag_neg == $past(i_result[15]) && o_flag_zero == ($past(i_result[15:0]) == 16'h0)))
    else $error("short destination flags wrong");

  chk_limit_arith: assert property (
    (i_valid && i_op_class == ccg_pkg::CCG_OP_ARITH && i_move_limited) |=> o_flag_lim)
    else $error("limit flag not set by move limiting");

  chk_logic_ovf: assert property (
    (i_valid && i_op_class == ccg_pkg::CCG_OP_LOGICAL) |=>
      (!o_flag_ovf && o_flag_carry == $past(i_logic_carry)))
    else $error("logical operation overflow or carry wrong");

  chk_bitfield_keep: assert property (
    (i_valid && i_op_class == ccg_pkg::CCG_OP_BITFIELD) |=>
      ($stable(o_flag_neg) && $stable(o_flag_zero) && $stable(o_flag_ovf)
       && $stable(o_flag_ext) && $stable(o_flag_unnorm)))
    else $error("bit-field operation changed other flags");

  chk_clear_other: assert property (
    (i_valid && !is_acc && i_op_class == ccg_pkg::CCG_OP_CLEAR) |=>
      ($stable(o_flag_lim) && $stable(o_flag_carry) && $stable(o_flag_zero) && !o_update_done))
    else $error("clear of a short register changed flags");

  chk_test_clears: assert property (
    (i_valid && i_op_class == ccg_pkg::CCG_OP_ACC_TEST) |=>
      (!o_flag_ovf && !o_flag_carry && o_flag_lim == $past(i_move_limited)))
    else $error("accumulator test flags wrong");

  chk_short_test: assert property (
    (i_valid && i_op_class == ccg_pkg::CCG_OP_SHORT_TEST) |=>
      (o_flag_lim == $past(i_read_limited) && !o_flag_ovf && !o_flag_carry
       && o_flag_zero == ($past(i_result[15:0]) == 16'h0)))
    else $error("short value test flags wrong");

  chk_idle_hold: assert property (
    !i_valid |=> (!o_update_done && $stable(o_flag_zero) && $stable(o_flag_neg)))
    else $error("flags moved without a request");

  cov_sat: cover property (arith_full && i_saturated ##1 o_update_done);
  cov_word_mode: cover property (
    i_valid && is_acc && mode_set && i_op_class == ccg_pkg::CCG_OP_WORD_INCDEC);
  cov_logic_acc: cover property (i_valid && is_acc && i_op_class == ccg_pkg::CCG_OP_LOGICAL);
  cov_back_to_back: cover property (i_valid ##1 i_valid ##1 o_update_done);

endmodule

//--- tb/ccg_core_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Core decoder and datapath stand-in: presents one flag request per call
// ----------------------------------------------------------------------------
module ccg_core_model (
  input wire logic i_core_clk,
  output logic o_valid,
  output ccg_pkg::ccg_op_class_t o_op_class,
  output ccg_pkg::ccg_dest_t o_dest,
  output logic o_mode,
  output logic [35:0] o_op_a,
  output logic [35:0] o_op_b,
  output logic [35:0] o_result,
  output logic o_sub,
  output logic [4:0] o_side
);
  initial begin
    o_valid = 1'b0;
    o_op_class = ccg_pkg::CCG_OP_NONE;
    o_dest = ccg_pkg::CCG_DEST_ACC;
    o_mode = 1'b0;
    o_op_a = 36'h0;
    o_op_b = 36'h0;
    o_result = 36'h0;
    o_sub = 1'b0;
    o_side = 5'h00;
  end

  // Called at a rising edge; returns at the edge that takes the request
  task automatic send(input ccg_pkg::ccg_op_class_t c, input ccg_pkg::ccg_dest_t d,
      input logic m, input logic [35:0] a, input logic [35:0] b, input logic s,
      input logic [4:0] sd);
    logic [35:0] r;
    r = s ? a - b : a + b;
    o_valid <= 1'b1;
    o_op_class <= c;
    o_dest <= d;
    o_mode <= m;
    o_op_a <= a;
    o_op_b <= b;
    o_result <= r;
    o_sub <= s;
    o_side <= sd;
    @(posedge i_core_clk);
    // Idle lines other than mode and sub carry the inverse so stale data is never mistaken for valid
    o_valid <= 1'b0;
    o_op_class <= ccg_pkg::ccg_op_class_t'(~c);
    o_dest <= ccg_pkg::ccg_dest_t'(~d);
    o_op_a <= ~a;
    o_op_b <= ~b;
    o_result <= ~r;
    o_side <= ~sd;
  endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps

module testbench;
  localparam logic [4:0] SAT = 5'h10;
  localparam logic [4:0] MVL = 5'h08;
  localparam logic [4:0] RDL = 5'h04;
  localparam logic [4:0] LC = 5'h02;
  localparam logic [4:0] BC = 5'h01;
  localparam ccg_pkg::ccg_dest_t d_acc = ccg_pkg::CCG_DEST_ACC;
  localparam ccg_pkg::ccg_dest_t d_short = ccg_pkg::CCG_DEST_SHORT;
  localparam ccg_pkg::ccg_op_class_t c_arith = ccg_pkg::CCG_OP_ARITH;
  localparam ccg_pkg::ccg_op_class_t c_word = ccg_pkg::CCG_OP_WORD_INCDEC;
  localparam ccg_pkg::ccg_op_class_t c_logic = ccg_pkg::CCG_OP_LOGICAL;
  localparam ccg_pkg::ccg_op_class_t c_bits = ccg_pkg::CCG_OP_BITFIELD;
  localparam ccg_pkg::ccg_op_class_t c_clear = ccg_pkg::CCG_OP_CLEAR;
  localparam ccg_pkg::ccg_op_class_t c_acc_test = ccg_pkg::CCG_OP_ACC_TEST;
  localparam ccg_pkg::ccg_op_class_t c_short_test = ccg_pkg::CCG_OP_SHORT_TEST;

  logic clk, rst, valid, mode, sub, done;
  ccg_pkg::ccg_op_class_t op_class;
  ccg_pkg::ccg_dest_t dest;
  logic [35:0] op_a, op_b, result;
  logic [4:0] side;
  logic f_lim, f_ext, f_un, f_neg, f_zero, f_ovf, f_cry;
  logic [6:0] flags, model_f;
  int error_cnt, total_checks;

  assign flags = {f_lim, f_ext, f_un, f_neg, f_zero, f_ovf, f_cry};

  ccg_core_model core (.i_core_clk(clk), .o_valid(valid), .o_op_class(op_class),
    .o_dest(dest), .o_mode(mode), .o_op_a(op_a), .o_op_b(op_b), .o_result(result),
    .o_sub(sub), .o_side(side));

  ccg_top uut (.i_core_clk(clk), .i_rst(rst), .i_valid(valid), .i_op_class(op_class),
    .i_dest(dest), .i_ignore_extension_mode_bit(mode), .i_op_a(op_a), .i_op_b(op_b),
    .i_result(result), .i_sub(sub), .i_saturated(side[4]), .i_move_limited(side[3]),
    .i_read_limited(side[2]), .i_logic_carry(side[1]), .i_bitfield_carry(side[0]),
    .o_flag_lim(f_lim), .o_flag_ext(f_ext), .o_flag_unnorm(f_un), .o_flag_neg(f_neg),
    .o_flag_zero(f_zero), .o_flag_ovf(f_ovf), .o_flag_carry(f_cry), .o_update_done(done));

  // --------------------------------------------------------------------------
  // Reference flag computation, order {L, E, U, N, Z, V, C}
  // --------------------------------------------------------------------------
  function automatic logic zr(input logic [35:0] r, input int h, input int l);
    zr = ((r >> l) & ((36'h1 << (h - l + 1)) - 36'h1)) == 36'h0;
  endfunction

  function automatic logic [6:0] expect_f(input ccg_pkg::ccg_op_class_t c,
      input ccg_pkg::ccg_dest_t d, input logic m, input logic [35:0] a,
      input logic [35:0] b, input logic s, input logic [4:0] sd, input logic [6:0] p);
    logic [35:0] r;
    logic [6:0] f;
    logic [1:0] eu;
    logic acc, sm, x, y, q, cy, ov;
    int h, l;
    r = s ? a - b : a + b;
    f = p;
    acc = d == d_acc;
    h = acc ? (m ? 31 : 35) : 15;
    l = (acc && c == c_word) ? 16 : 0;
    sm = sd[4] & acc & ~m;
    x = a[h];
    y = b[h] ^ s;
    q = r[h];
    cy = ((x & y) | ((x | y) & ~q)) ^ s;
    ov = (x ~^ y) & (q ^ x);
    eu = {r[35:31] != 5'h00 && r[35:31] != 5'h1f, r[31] ~^ r[30]};
    case (c)
      c_arith, c_word: f = {ov | sm | sd[3], eu, r[h] & ~sm, zr(r, h, l), ov | sm, cy};
      c_logic: f = {sd[3], eu, r[acc ? 31 : 15], zr(r, acc ? 31 : 15, acc ? 16 : 0),
        1'b0, sd[1]};
      c_bits: f = {sd[3], p[5:1], sd[0]};
      c_clear, c_acc_test: if (acc) f = {sd[3], eu, r[h], zr(r, h, 0), 2'b00};
      c_short_test: f = {sd[2], p[5:4], r[15], zr(r, 15, 0), 2'b00};
      default: f = p;
    endcase
    return f;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic run(input ccg_pkg::ccg_op_class_t c, input ccg_pkg::ccg_dest_t d,
      input logic m, input logic [35:0] a, input logic [35:0] b, input logic s,
      input logic [4:0] sd);
    logic [6:0] e;
    logic ok;
    ok = c != ccg_pkg::CCG_OP_NONE && !(c == c_clear && d == d_short);
    e = expect_f(c, d, m, a, b, s, sd, model_f);
    model_f = e;
    core.send(c, d, m, a, b, s, sd);
    @(negedge clk);
    check("flags", {1'b0, flags}, {1'b0, e});
    check("done", {7'h00, done}, {7'h00, ok});
    @(posedge clk);
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (1000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    total_checks = 0;
    rst = 1'b1;
    model_f = 7'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("reset", {flags, done}, 8'h00);
    @(posedge clk);
    run(c_arith, d_acc, 1'b0, 36'h0_0000_0001, 36'h0_0000_0001, 1'b1, 5'h00);
    run(c_arith, d_acc, 1'b0, 36'h7_ffff_ffff, 36'h0_0000_0001, 1'b0, 5'h00);
    run(c_arith, d_acc, 1'b0, 36'hf_ffff_ffff, 36'h0_0000_0001, 1'b0, 5'h00);
    run(c_arith, d_acc, 1'b0, 36'h0_0000_0001, 36'h0_0000_0001, 1'b0, MVL);
    run(c_arith, d_acc, 1'b0, 36'hf_8000_0000, 36'h0_0000_0000, 1'b0, SAT);
    run(c_arith, d_acc, 1'b0, 36'h0_0000_0000, 36'h0_0000_0001, 1'b1, 5'h00);
    for (int m = 0; m < 2; m++) begin
      run(c_arith, d_acc, m[0], 36'h0_7fff_ffff, 36'h0_0000_0001, 1'b0, 5'h00);
      run(c_arith, d_short, m[0], 36'h0_0000_7fff, 36'h0_0000_0001, 1'b0, 5'h00);
      run(c_arith, d_short, m[0], 36'h0_0000_0000, 36'h0_0000_0001, 1'b1, 5'h00);
      run(c_logic, d_acc, m[0], 36'h0_0000_ffff, 36'h0_0000_0000, 1'b0, 5'h00);
    end
    run(c_arith, d_acc, 1'b1, 36'h0_7fff_ffff, 36'h0_0000_0001, 1'b0, 5'h00);
    run(c_arith, d_acc, 1'b1, 36'h0_ffff_ffff, 36'h0_0000_0001, 1'b0, 5'h00);
    run(c_arith, d_acc, 1'b1, 36'h1_0000_0000, 36'h0_0000_0000, 1'b0, 5'h00);
    // Reset again with flags set; two edges so no check straddles the release
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    model_f = 7'h00;
    @(negedge clk);
    check("reset", {flags, done}, 8'h00);
    @(posedge clk);
    run(c_word, d_acc, 1'b0, 36'h7_ffff_1234, 36'h0_0001_0000, 1'b0, 5'h00);
    run(c_word, d_acc, 1'b0, 36'hf_ffff_1234, 36'h0_0001_0000, 1'b0, 5'h00);
    run(c_word, d_acc, 1'b1, 36'h0_7fff_5555, 36'h0_0001_0000, 1'b0, 5'h00);
    run(c_word, d_acc, 1'b1, 36'h3_ffff_0001, 36'h0_0001_0000, 1'b0, 5'h00);
    run(c_word, d_acc, 1'b1, 36'h0_0000_0000, 36'h0_0001_0000, 1'b1, 5'h00);
    run(c_word, d_acc, 1'b0, 36'h8_0000_0000, 36'h0_0001_0000, 1'b1, SAT);
    run(c_word, d_short, 1'b1, 36'h0_0000_ffff, 36'h0_0000_0001, 1'b0, 5'h00);
    run(c_logic, d_short, 1'b0, 36'h0_0000_8000, 36'h0_0000_0000, 1'b0, LC);
    run(c_logic, d_acc, 1'b0, 36'h0_8000_0000, 36'h0_0000_0000, 1'b0, LC | MVL);
    run(c_bits, d_acc, 1'b0, 36'h0_0000_0000, 36'h0_0000_0000, 1'b0, 5'h00);
    run(c_bits, d_short, 1'b1, 36'h8_0000_0000, 36'h0_0000_0000, 1'b0, BC | MVL);
    run(c_arith, d_acc, 1'b0, 36'h0_0000_0000, 36'h0_0000_0001, 1'b1, MVL);
    run(c_clear, d_short, 1'b0, 36'h0_0000_0000, 36'h0_0000_0000, 1'b0, 5'h00);
    run(c_clear, d_acc, 1'b0, 36'h0_0000_0000, 36'h0_0000_0000, 1'b0, 5'h00);
    run(c_acc_test, d_acc, 1'b0, 36'h8_0000_0000, 36'h0_0000_0000, 1'b0, MVL);
    run(c_acc_test, d_acc, 1'b1, 36'h8_0000_0000, 36'h0_0000_0000, 1'b0, 5'h00);
    run(c_short_test, d_short, 1'b0, 36'h0_0000_0000, 36'h0_0000_0000, 1'b0, RDL);
    run(c_short_test, d_short, 1'b1, 36'h0_0000_8000, 36'h0_0000_0000, 1'b0, MVL);
    run(ccg_pkg::CCG_OP_NONE, d_acc, 1'b0, 36'h0_0000_0001, 36'h0, 1'b0, SAT);
    wrap_up;
  end
endmodule
